//--- logic/fws_pkg.sv
// Purpose: shared constants for the flash write sequencer
// Assumes: 16-bit cpu flash port, 32-bit axi4-lite register bus
// Notes:   register words hold 16 bits in the low half, upper half reads zero
package fws_pkg;
	localparam int          CPU_AW          = 20;
	localparam int          AXI_AW          = 12;
	localparam int          LW_BASE_W       = CPU_AW - 2;
	// register byte offsets
	localparam logic [11:0] OFF_CTL_ONE     = 12'h000;
	localparam logic [11:0] OFF_CTL_THREE   = 12'h004;
	localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h008;
	// password handling
	localparam logic [7:0]  KEY_WRITE       = 8'hA5;
	localparam logic [7:0]  KEY_READ        = 8'h96;
	// flash_control_one fields
	localparam int          BIT_BLOCK_MODE  = 7;
	localparam int          BIT_WRITE_EN    = 6;
	// flash_control_three fields
	localparam int          BIT_BUSY        = 0;
	localparam int          BIT_KEY_VIOLATION_FLAG        = 1;
	localparam int          BIT_ACCV        = 2;
	localparam int          BIT_WAIT        = 3;
	localparam int          BIT_LOCK        = 4;
	// irq enable field
	localparam int          BIT_ACCV_IE     = 0;
	localparam logic        LOCK_RESET      = 1'b1;
	// one row is 128 bytes, i.e. 32 long-words
	localparam int          ROW_BYTES       = 128;
	localparam int          LWORDS_PER_ROW  = ROW_BYTES / 4;
	localparam logic [4:0]  LAST_LWORD      = 5'(LWORDS_PER_ROW - 1);
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_BYTE_WORD,
		MODE_LONG_WORD,
		MODE_BLOCK
	} fws_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROG,
		ST_BLK_WAIT,
		ST_BLK_PROG
	} fws_state_t;
endpackage

//--- logic/fws_sticky.sv
// Purpose: sticky flag, hardware set beats software clear
// Assumes: set and clear are single-cycle same-clock strobes
// Notes:   used for the access and key violation flags
`timescale 1ns/1ps
module fws_sticky (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_q
);
	import fws_pkg::*;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_q <= 1'b0;
		else if (i_set)
			o_q <= 1'b1;
		else if (i_clr)
			o_q <= 1'b0;
	end

	property p_set_wins;
		@(posedge i_clk) disable iff (!i_resetn) i_set |=> o_q;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost a set");
endmodule

//--- logic/fws_lword.sv
// Purpose: gathers bytes of one aligned long-word
// Assumes: 16-bit writes with two byte enables
// Notes:   o_full is registered; caller clears after taking it
`timescale 1ns/1ps
module fws_lword (
	input  wire logic                           i_clk,
	input  wire logic                           i_resetn,
	input  wire logic                           i_clr,
	input  wire logic                           i_wr,
	input  wire logic [fws_pkg::CPU_AW-1:0]     i_addr,
	input  wire logic [1:0]                     i_be,
	input  wire logic [15:0]                    i_wdata,
	output logic                                o_full,
	output logic [fws_pkg::LW_BASE_W-1:0]       o_base,
	output logic [31:0]                         o_data
);
	import fws_pkg::*;
	logic [3:0]           have;
	logic [3:0]           wr_mask_q;
	wire  [LW_BASE_W-1:0] wr_base  = i_addr[CPU_AW-1:2];
	wire  [3:0]           wr_mask  = i_addr[1] ? {i_be, 2'b00} : {2'b00, i_be};
	// a write outside the pending long-word restarts collection
	wire                  same     = (have == 4'h0) || (wr_base == o_base);
	wire  [3:0]           keep     = same ? have : 4'h0;
	wire  [3:0]           next_have = keep | wr_mask;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			have   <= 4'h0;
			o_base <= '0;
			o_full <= 1'b0;
		end else if (i_clr) begin
			have   <= 4'h0;
			o_full <= 1'b0;
		end else if (i_wr) begin
			have   <= next_have;
			o_base <= wr_base;
			o_full <= (next_have == 4'hF);
		end
	end

	// newest byte overwrites the lane, unless i_clr is high in the same cycle
	for (genvar g = 0; g < 4; g++) begin : g_lane
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn)
				o_data[g*8 +: 8] <= 8'h00;
			else if (i_wr && !i_clr && wr_mask[g])
				o_data[g*8 +: 8] <= i_wdata[(g%2)*8 +: 8];
		end
	end

	property p_restart;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_wr && !i_clr && have != 4'h0 && wr_base != o_base) |=> (have == wr_mask_q) && !o_full;
	endproperty
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			wr_mask_q <= 4'h0;
		else
			wr_mask_q <= wr_mask;
	end
	a_restart: assert property (p_restart) else $error("stale bytes kept");
endmodule

//--- logic/fws_top.sv
// Purpose: flash write sequencer, byte/word, long-word and block programming
// Assumes: cpu port and flash array logic run on i_clk; array answers i_prog_done
// Notes:   registers on axi4-lite; 16-bit values, password in bits 15:8
`timescale 1ns/1ps
module fws_top (
	input  wire logic                           i_clk,
	input  wire logic                           i_resetn,
	input  wire logic                           i_axi_awvalid,
	output logic                                o_axi_awready,
	input  wire logic [fws_pkg::AXI_AW-1:0]     i_axi_awaddr,
	input  wire logic                           i_axi_wvalid,
	output logic                                o_axi_wready,
	input  wire logic [31:0]                    i_axi_wdata,
	input  wire logic [3:0]                     i_axi_wstrb,
	output logic                                o_axi_bvalid,
	input  wire logic                           i_axi_bready,
	output logic [1:0]                          o_axi_bresp,
	input  wire logic                           i_axi_arvalid,
	output logic                                o_axi_arready,
	input  wire logic [fws_pkg::AXI_AW-1:0]     i_axi_araddr,
	output logic                                o_axi_rvalid,
	input  wire logic                           i_axi_rready,
	output logic [31:0]                         o_axi_rdata,
	output logic [1:0]                          o_axi_rresp,
	input  wire logic                           i_cpu_req,
	input  wire logic                           i_cpu_we,
	input  wire logic                           i_cpu_fetch,
	input  wire logic                           i_cpu_from_ram,
	input  wire logic [fws_pkg::CPU_AW-1:0]     i_cpu_addr,
	input  wire logic [1:0]                     i_cpu_be,
	input  wire logic [15:0]                    i_cpu_wdata,
	output logic                                o_cpu_stall,
	output logic                                o_prog_start,
	output logic [fws_pkg::CPU_AW-1:0]          o_prog_addr,
	output logic [31:0]                         o_prog_data,
	output logic [3:0]                          o_prog_mask,
	output logic                                o_vpp_on,
	input  wire logic                           i_prog_done,
	output logic                                o_busy,
	output logic                                o_wait_flag,
	output logic                                o_nmi_req,
	output logic                                o_sys_reset
);
	import fws_pkg::*;

	fws_state_t state;
	fws_state_t next_state;
	logic       block_mode_bit;
	logic       write_enable_bit;
	logic       lock;
	logic       access_violation_irq_enable;
	logic       access_violation_flag;
	logic       key_violation_flag;
	logic       blk_hold;
	logic [4:0] lw_count;
	logic       aw_held;
	logic       w_held;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// mode decode
	wire fws_mode_t mode = (!block_mode_bit && write_enable_bit) ? MODE_BYTE_WORD :
	                       (block_mode_bit && !write_enable_bit) ? MODE_LONG_WORD :
	                       (block_mode_bit && write_enable_bit)  ? MODE_BLOCK : MODE_NONE;

	// cpu side events
	wire cpu_wr      = i_cpu_req && i_cpu_we;
	wire cpu_fetch   = i_cpu_req && i_cpu_fetch;
	wire idle        = (state == ST_IDLE);
	wire may_prog    = idle && !lock && !blk_hold && (mode != MODE_NONE);
	wire bw_start    = may_prog && cpu_wr && (mode == MODE_BYTE_WORD);
	wire coll_full;
	wire [LW_BASE_W-1:0] coll_base;
	wire [31:0] coll_data;
	wire lw_start    = may_prog && (mode == MODE_LONG_WORD) && coll_full;
	wire blk_enter   = may_prog && cpu_wr && (mode == MODE_BLOCK);
	wire blk_issue   = (state == ST_BLK_WAIT) && coll_full;
	wire coll_wr     = cpu_wr && ((may_prog && mode != MODE_BYTE_WORD)
	                   || (state == ST_BLK_WAIT && !coll_full));
	wire coll_clr    = lw_start || blk_issue || !block_mode_bit;
	wire start_any   = bw_start || lw_start || blk_issue;
	// access while busy: prog cycle from ram, or block with wait low, or fetch in block
	wire viol_prog   = (state == ST_PROG) && i_cpu_req;
	wire blk_abort   = ((state == ST_BLK_PROG) && i_cpu_req) || ((state == ST_BLK_WAIT) && cpu_fetch);
	wire row_end     = (state == ST_BLK_PROG) && i_prog_done && (lw_count == LAST_LWORD);

	// register bus decode
	wire        wr_fire   = aw_held && w_held && !o_axi_bvalid;
	wire [11:0] wr_off    = aw_addr[11:0];
	wire        wr_word   = (w_strb[1:0] == 2'b11);
	wire        wr_mapped = (wr_off == OFF_CTL_ONE) || (wr_off == OFF_CTL_THREE) || (wr_off == OFF_IRQ_ENABLE);
	wire        wr_ok     = wr_fire && wr_mapped && wr_word;
	wire        key_good  = (w_data[15:8] == KEY_WRITE);
	wire        key_bad   = wr_ok && !key_good;
	wire        wr_one    = wr_ok && key_good && (wr_off == OFF_CTL_ONE);
	wire        wr_three  = wr_ok && key_good && (wr_off == OFF_CTL_THREE);
	wire        wr_ie     = wr_ok && key_good && (wr_off == OFF_IRQ_ENABLE);
	// control one may change only when idle or when block mode has wait high
	wire        one_ok    = idle || (state == ST_BLK_WAIT);
	wire        viol_reg  = wr_one && !one_ok;
	wire        accv_set  = viol_prog || blk_abort || viol_reg;
	wire [11:0] rd_off    = i_axi_araddr[11:0];
	wire [15:0] rd_one    = {KEY_READ, block_mode_bit, write_enable_bit, 6'h00};
	wire [15:0] rd_three  = {KEY_READ, 3'h0, lock, o_wait_flag, access_violation_flag, key_violation_flag, o_busy};
	wire [15:0] rd_ie     = {KEY_READ, 7'h00, access_violation_irq_enable};
	wire        rd_mapped = (rd_off == OFF_CTL_ONE) || (rd_off == OFF_CTL_THREE) || (rd_off == OFF_IRQ_ENABLE);
	wire [15:0] rd_val    = (rd_off == OFF_CTL_ONE) ? rd_one : (rd_off == OFF_CTL_THREE) ? rd_three :
	                        (rd_off == OFF_IRQ_ENABLE) ? rd_ie : 16'h0000;

	fws_lword u_lword (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_clr    (coll_clr),
		.i_wr     (coll_wr),
		.i_addr   (i_cpu_addr),
		.i_be     (i_cpu_be),
		.i_wdata  (i_cpu_wdata),
		.o_full   (coll_full),
		.o_base   (coll_base),
		.o_data   (coll_data)
	);

	fws_sticky u_accv (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_set    (accv_set),
		.i_clr    (wr_three && !w_data[BIT_ACCV]),
		.o_q      (access_violation_flag)
	);

	fws_sticky u_key_violation_flag (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_set    (key_bad),
		.i_clr    (wr_three && !w_data[BIT_KEY_VIOLATION_FLAG]),
		.o_q      (key_violation_flag)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (bw_start || lw_start)
					next_state = ST_PROG;
				else if (blk_enter)
					next_state = ST_BLK_WAIT;
			end
			ST_PROG: begin
				if (i_prog_done)
					next_state = ST_IDLE;
			end
			ST_BLK_WAIT: begin
				if (blk_abort)
					next_state = ST_IDLE;
				else if (blk_issue)
					next_state = ST_BLK_PROG;
			end
			ST_BLK_PROG: begin
				if (blk_abort || row_end)
					next_state = ST_IDLE;
				else if (i_prog_done)
					next_state = ST_BLK_WAIT;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state       <= ST_IDLE;
			o_busy      <= 1'b0;
			o_wait_flag <= 1'b0;
			o_vpp_on    <= 1'b0;
		end else begin
			state       <= next_state;
			o_busy      <= (next_state != ST_IDLE);
			o_wait_flag <= (next_state == ST_BLK_WAIT);
			o_vpp_on    <= (next_state != ST_IDLE);
		end
	end

	// cpu held only when the write came from code in flash
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_cpu_stall <= 1'b0;
		else if ((bw_start || lw_start) && !i_cpu_from_ram)
			o_cpu_stall <= 1'b1;
		else if (state == ST_PROG && i_prog_done)
			o_cpu_stall <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_prog_start <= 1'b0;
			o_prog_addr  <= '0;
			o_prog_data  <= 32'h0000_0000;
			o_prog_mask  <= 4'h0;
		end else begin
			o_prog_start <= start_any;
			if (bw_start) begin
				o_prog_addr <= {i_cpu_addr[CPU_AW-1:2], 2'b00};
				o_prog_data <= {i_cpu_wdata, i_cpu_wdata};
				o_prog_mask <= i_cpu_addr[1] ? {i_cpu_be, 2'b00} : {2'b00, i_cpu_be};
			end else if (lw_start || blk_issue) begin
				o_prog_addr <= {coll_base, 2'b00};
				o_prog_data <= coll_data;
				o_prog_mask <= 4'hF;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			lw_count <= 5'h00;
		else if (blk_enter || blk_abort || row_end)
			lw_count <= 5'h00;
		else if (state == ST_BLK_PROG && i_prog_done)
			lw_count <= lw_count + 5'h01;
	end

	// after a block ends, a new one waits until software drops block mode
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			blk_hold <= 1'b0;
		else if (blk_abort || row_end)
			blk_hold <= 1'b1;
		else if (!block_mode_bit)
			blk_hold <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			block_mode_bit              <= 1'b0;
			write_enable_bit            <= 1'b0;
			lock                        <= LOCK_RESET;
			access_violation_irq_enable <= 1'b0;
		end else begin
			if (wr_one && one_ok) begin
				block_mode_bit   <= w_data[BIT_BLOCK_MODE];
				write_enable_bit <= w_data[BIT_WRITE_EN];
			end
			// hardware lock on abort beats a software unlock
			if (blk_abort)
				lock <= 1'b1;
			else if (wr_three)
				lock <= w_data[BIT_LOCK];
			if (wr_ie)
				access_violation_irq_enable <= w_data[BIT_ACCV_IE];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_nmi_req   <= 1'b0;
			o_sys_reset <= 1'b0;
		end else begin
			o_nmi_req   <= access_violation_flag && access_violation_irq_enable;
			o_sys_reset <= key_bad;
		end
	end

	// axi4-lite write: address and data taken in either order
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp  <= RESP_OKAY;
		end else begin
			if (i_axi_awvalid && o_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_axi_awaddr;
			end else if (wr_fire)
				aw_held <= 1'b0;
			if (i_axi_wvalid && o_axi_wready) begin
				w_held <= 1'b1;
				w_data <= i_axi_wdata;
				w_strb <= i_axi_wstrb;
			end else if (wr_fire)
				w_held <= 1'b0;
			if (wr_fire) begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= (wr_mapped && wr_word) ? RESP_OKAY : RESP_SLVERR;
			end else if (i_axi_bready)
				o_axi_bvalid <= 1'b0;
		end
	end
	assign o_axi_awready = !aw_held;
	assign o_axi_wready  = !w_held;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_axi_rvalid <= 1'b0;
			o_axi_rdata  <= 32'h0000_0000;
			o_axi_rresp  <= RESP_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			o_axi_rvalid <= 1'b1;
			o_axi_rdata  <= {16'h0000, rd_val};
			o_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_axi_rready)
			o_axi_rvalid <= 1'b0;
	end
	assign o_axi_arready = !o_axi_rvalid;

	property p_bw_start;
		@(posedge i_clk) disable iff (!i_resetn) bw_start |=> o_prog_start && o_busy && o_prog_mask != 4'h0;
	endproperty
	a_bw_start: assert property (p_bw_start) else $error("byte/word write not started");
	property p_busy_end;
		@(posedge i_clk) disable iff (!i_resetn) (state == ST_PROG && i_prog_done) |=> !o_busy && !o_cpu_stall;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy not cleared");
	property p_viol;
		@(posedge i_clk) disable iff (!i_resetn) (state == ST_PROG && i_cpu_req) |=> ##1 access_violation_flag;
	endproperty
	a_viol: assert property (p_viol) else $error("violation not flagged");
	property p_stall_flash;
		@(posedge i_clk) disable iff (!i_resetn) (bw_start && !i_cpu_from_ram) |=> o_cpu_stall && o_busy;
	endproperty
	a_stall_flash: assert property (p_stall_flash) else $error("cpu not held");
	property p_nostall_ram;
		@(posedge i_clk) disable iff (!i_resetn) (start_any && i_cpu_from_ram && !o_cpu_stall) |=> !o_cpu_stall;
	endproperty
	a_nostall_ram: assert property (p_nostall_ram) else $error("cpu held from ram");
	property p_lw_wait;
		@(posedge i_clk) disable iff (!i_resetn) (idle && mode == MODE_LONG_WORD && !coll_full) |=> !o_busy;
	endproperty
	a_lw_wait: assert property (p_lw_wait) else $error("busy before 32 bits");
	property p_blk_prog;
		@(posedge i_clk) disable iff (!i_resetn) (state == ST_BLK_PROG) |-> o_vpp_on && o_busy && !o_wait_flag;
	endproperty
	a_blk_prog: assert property (p_blk_prog) else $error("block flags wrong");
	property p_abort;
		@(posedge i_clk) disable iff (!i_resetn) (state == ST_BLK_PROG && i_cpu_req) |=> lock && access_violation_flag && idle;
	endproperty
	a_abort: assert property (p_abort) else $error("block not aborted");
	property p_key;
		@(posedge i_clk) disable iff (!i_resetn) key_bad |=> o_sys_reset && key_violation_flag;
	endproperty
	a_key: assert property (p_key) else $error("bad key not caught");
	property p_lock;
		@(posedge i_clk) disable iff (!i_resetn) (idle && lock && cpu_wr) |=> !o_prog_start && !o_busy;
	endproperty
	a_lock: assert property (p_lock) else $error("write while locked");
endmodule

//--- tb/fws_flash_model.sv
// Purpose: flash array stand-in, answers each program start with done
// Assumes: done is a one-cycle pulse on i_clk
// Notes:   delay is a port so the bench can answer promptly or slowly
`timescale 1ns/1ps
module fws_flash_model (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_start,
	input  wire logic [7:0] i_delay,
	output logic            o_done
);
	logic [7:0] cnt;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt    <= 8'h00;
			o_done <= 1'b0;
		end else begin
			o_done <= (cnt == 8'h01);
			cnt    <= i_start ? i_delay : (cnt != 8'h00) ? cnt - 8'h01 : cnt;
		end
	end
endmodule

//--- tb/fws_top_tb.sv
// Purpose: self-checking bench for the flash write sequencer
// Assumes: registers on axi4-lite, array answers through the model
// Notes:   a delay of 0 would never answer, so the bench keeps it larger
`timescale 1ns/1ps
module fws_top_tb;
	import fws_pkg::*;
	logic        i_clk = 1'b0, i_resetn = 1'b0, i_prog_done;
	logic        i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
	logic        i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
	logic [11:0] i_axi_awaddr = 12'h000, i_axi_araddr = 12'h000;
	logic [31:0] i_axi_wdata = 32'h0000_0000, rd, o_axi_rdata, o_prog_data;
	logic [3:0]  i_axi_wstrb = 4'hf, o_prog_mask;
	logic        i_cpu_req = 1'b0, i_cpu_we = 1'b0, i_cpu_fetch = 1'b0, i_cpu_from_ram = 1'b0;
	logic [19:0] i_cpu_addr = 20'h0_0000, o_prog_addr;
	logic [1:0]  i_cpu_be = 2'h3, rsp, o_axi_bresp, o_axi_rresp;
	logic [15:0] i_cpu_wdata = 16'h0000;
	logic [7:0]  delay = 8'h06;
	logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
	logic        o_cpu_stall, o_prog_start, o_vpp_on, o_busy, o_wait_flag, o_nmi_req, o_sys_reset;
	int          bad_count = 0, total_checks = 0, cycles = 0, starts = 0, resets = 0, s0;
	fws_top uut (.i_clk, .i_resetn, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr, .i_axi_wvalid, .o_axi_wready,
		.i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid, .i_axi_bready, .o_axi_bresp, .i_axi_arvalid, .o_axi_arready,
		.i_axi_araddr, .o_axi_rvalid, .i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_cpu_req, .i_cpu_we,
		.i_cpu_fetch, .i_cpu_from_ram, .i_cpu_addr, .i_cpu_be, .i_cpu_wdata, .o_cpu_stall, .o_prog_start,
		.o_prog_addr, .o_prog_data, .o_prog_mask, .o_vpp_on, .i_prog_done, .o_busy, .o_wait_flag,
		.o_nmi_req, .o_sys_reset);
	fws_flash_model array (.i_clk, .i_resetn, .i_start(o_prog_start), .i_delay(delay), .o_done(i_prog_done));
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		starts += o_prog_start;
		resets += o_sys_reset;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_axi_awvalid <= 1'b1;
		i_axi_wvalid  <= 1'b1;
		i_axi_awaddr  <= a;
		i_axi_wdata   <= {16'h0000, d};
		i_axi_bready  <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_axi_awready) i_axi_awvalid <= 1'b0;
			if (o_axi_wready) i_axi_wvalid <= 1'b0;
		end while (o_axi_bvalid !== 1'b1);
		rsp = o_axi_bresp;
		i_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge i_clk);
		i_axi_arvalid <= 1'b1;
		i_axi_araddr  <= a;
		i_axi_rready  <= 1'b1;
		do begin
			@(posedge i_clk);
			if (o_axi_arready) i_axi_arvalid <= 1'b0;
		end while (o_axi_rvalid !== 1'b1);
		rd  = o_axi_rdata;
		rsp = o_axi_rresp;
		i_axi_rready <= 1'b0;
	endtask
	task automatic cpu(input logic w, rm, input logic [19:0] a, input logic [1:0] b, input logic [15:0] d);
		@(posedge i_clk);
		i_cpu_req      <= 1'b1;
		i_cpu_we       <= w;
		i_cpu_from_ram <= rm;
		i_cpu_addr     <= a;
		i_cpu_be       <= b;
		i_cpu_wdata    <= d;
		@(posedge i_clk);
		i_cpu_req <= 1'b0;
		#1;
	endtask
	task automatic idle();
		int n = 0;
		while (o_busy !== 1'b0 && n < 200) begin
			@(posedge i_clk);
			n++;
		end
		#1;
		chk("busy clears", o_busy, 0);
	endtask
	// wait flag poll; a dropped busy also ends it
	task automatic poll(input logic v);
		int n = 0;
		while (o_wait_flag !== v && o_busy === 1'b1 && n < 100) begin
			@(posedge i_clk);
			n++;
		end
		#1;
	endtask
	task automatic t_reset();
		rdr(OFF_CTL_ONE);
		chk("ctl1", rd, 32'h0000_9600);
		rdr(OFF_CTL_THREE);
		chk("ctl3", rd, 32'h0000_9610);
		rdr(12'h00c);
		chk("unmapped", rsp, RESP_SLVERR);
		wr(12'h00c, 16'ha500);
		chk("wr unmapped", rsp, RESP_SLVERR);
		$display("reset test done");
	endtask
	task automatic t_bw();
		wr(OFF_CTL_THREE, 16'ha500);
		wr(OFF_CTL_ONE, 16'ha540);
		chk("bresp", rsp, RESP_OKAY);
		cpu(1, 0, 20'h0_1002, 2'h3, 16'h1234);
		chk("stall", o_cpu_stall, 1);
		chk("busy", o_busy, 1);
		chk("addr", o_prog_addr, 20'h0_1000);
		chk("mask", o_prog_mask, 4'hc);
		idle();
		chk("stall off", o_cpu_stall, 0);
		cpu(1, 1, 20'h0_1004, 2'h3, 16'h5678);
		chk("no stall", o_cpu_stall, 0);
		cpu(0, 1, 20'h0_1008, 2'h3, 16'h0000);
		idle();
		rdr(OFF_CTL_THREE);
		chk("accv", rd[BIT_ACCV], 1);
		wr(OFF_IRQ_ENABLE, 16'ha501);
		repeat (2) @(posedge i_clk);
		#1;
		chk("nmi", o_nmi_req, 1);
		wr(OFF_CTL_THREE, 16'ha500);
		repeat (2) @(posedge i_clk);
		#1;
		chk("nmi off", o_nmi_req, 0);
		$display("byte word test done");
	endtask
	task automatic t_lword();
		wr(OFF_CTL_ONE, 16'ha580);
		delay <= 8'h20;
		cpu(1, 1, 20'h0_2004, 2'h1, 16'h00aa);
		cpu(1, 1, 20'h0_3000, 2'h1, 16'h0011);
		cpu(1, 1, 20'h0_3000, 2'h3, 16'h2233);
		repeat (3) @(posedge i_clk);
		#1;
		chk("busy early", o_busy, 0);
		cpu(1, 1, 20'h0_3002, 2'h3, 16'h4455);
		repeat (2) @(posedge i_clk);
		#1;
		chk("busy lw", o_busy, 1);
		chk("no stall", o_cpu_stall, 0);
		chk("lw addr", o_prog_addr, 20'h0_3000);
		chk("lw data", o_prog_data, 32'h4455_2233);
		chk("lw mask", o_prog_mask, 4'hf);
		idle();
		cpu(1, 0, 20'h0_3004, 2'h3, 16'h6677);
		cpu(1, 0, 20'h0_3006, 2'h3, 16'h8899);
		repeat (2) @(posedge i_clk);
		#1;
		chk("stall lw", o_cpu_stall, 1);
		chk("lw data2", o_prog_data, 32'h8899_6677);
		idle();
		chk("stall off", o_cpu_stall, 0);
		$display("long word test done");
	endtask
	// block writes come from ram, each row written once
	task automatic t_block();
		delay <= 8'h03;
		wr(OFF_CTL_ONE, 16'ha5c0);
		s0 = starts;
		for (int i = 0; i < 32; i++) begin
			poll(1);
			if (i > 0) begin
				chk("blk busy", o_busy, 1);
				chk("blk vpp", o_vpp_on, 1);
				chk("blk wait", o_wait_flag, 1);
			end
			cpu(1, 1, 20'h0_4000 + 20'(i * 4), 2'h3, 16'(i));
			cpu(1, 1, 20'h0_4002 + 20'(i * 4), 2'h3, 16'(~i));
			poll(0);
		end
		poll(1);
		idle();
		chk("blk starts", starts - s0, 32);
		wr(OFF_CTL_ONE, 16'ha500);
		repeat (4) @(posedge i_clk);
		$display("block test done");
	endtask
	task automatic t_abort();
		wr(OFF_CTL_ONE, 16'ha5c0);
		cpu(1, 1, 20'h0_5000, 2'h3, 16'h1111);
		cpu(1, 1, 20'h0_5002, 2'h3, 16'h2222);
		poll(0);
		cpu(0, 1, 20'h0_5008, 2'h3, 16'h0000);
		idle();
		rdr(OFF_CTL_THREE);
		chk("lock", rd[BIT_LOCK], 1);
		chk("accv", rd[BIT_ACCV], 1);
		wr(OFF_CTL_ONE, 16'ha540);
		s0 = starts;
		cpu(1, 1, 20'h0_6000, 2'h3, 16'h3333);
		repeat (3) @(posedge i_clk);
		#1;
		chk("locked busy", o_busy, 0);
		chk("locked starts", starts - s0, 0);
		wr(OFF_CTL_THREE, 16'ha500);
		wr(OFF_CTL_ONE, 16'ha5c0);
		cpu(1, 1, 20'h0_7000, 2'h3, 16'h4444);
		i_cpu_fetch <= 1'b1;
		cpu(0, 1, 20'h0_7004, 2'h3, 16'h0000);
		i_cpu_fetch <= 1'b0;
		idle();
		rdr(OFF_CTL_THREE);
		chk("fetch lock", rd[BIT_LOCK], 1);
		chk("fetch accv", rd[BIT_ACCV], 1);
		$display("abort test done");
	endtask
	task automatic t_key();
		s0 = resets;
		wr(OFF_CTL_ONE, 16'h1240);
		repeat (2) @(posedge i_clk);
		chk("sys reset", resets - s0, 1);
		rdr(OFF_CTL_THREE);
		chk("key_violation_flag", rd[BIT_KEY_VIOLATION_FLAG], 1);
		$display("key test done");
	endtask
	initial begin
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_bw();
		t_lword();
		t_block();
		t_abort();
		t_key();
		give_verdict();
	end
endmodule
